// >>> gpio_port_pkg.sv
// Constants and types shared by the six-pin port files
package gpio_port_pkg;
  // =====================================================
  // Register file addresses and widths
  localparam logic [4:0] status_addr    = 5'h03;
  localparam logic [4:0] port_addr      = 5'h06;
  localparam int         pin_count      = 6;
  // =====================================================
  // Values after reset
  localparam logic [5:0] direction_reset = 6'h3f;
  localparam logic [7:0] options_reset   = 8'hff;
  localparam logic [5:0] latch_reset     = 6'h00;
  // =====================================================
  // Field positions
  localparam int opt_wake_disable_bit = 7;
  localparam int opt_pull_disable_bit = 6;
  localparam int opt_timer_src_bit    = 5;
  localparam int status_wake_flag_bit = 7;
  localparam int input_only_idx       = 3;
  localparam int second_pin_idx       = 2;
  // Pins that carry pull-ups and wake-on-change: zero, one, input-only
  localparam logic [5:0] weak_pin_mask = 6'h0b;
  // =====================================================
  // Port access operations issued by the core
  typedef enum logic [2:0] {
    op_none      = 3'b000,
    op_write     = 3'b001,
    op_read      = 3'b010,
    op_bit_set   = 3'b011,
    op_bit_clear = 3'b100
  } port_op_t;
endpackage

// >>> pin_load_model.sv
// Model of the external circuitry on the six port pins
`timescale 1ns/1ps
`default_nettype none
module pin_load_model
(
  // Clock
  input  wire logic       sys_clk,
  // Port side
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] pull_up_on,
  // Bench control
  input  wire logic [5:0] ext_level,
  input  wire logic [5:0] ext_drive,
  output logic      [5:0] pin_in
);
  logic [5:0] drift = 6'h15;
  // Floating pins wander so a stale value never reads as correct
  always @(posedge sys_clk) drift <= ~drift;
  always_comb
    for (int i = 0; i < 6; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i]
                : ext_drive[i] ? ext_level[i] : pull_up_on[i] ? 1'b1 : drift[i];
endmodule
`default_nettype wire

// >>> pin_sync.sv
// Two-stage synchroniser for the six port pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Pins
  input  wire logic [5:0] pin_async,
  output var  logic [5:0] pin_synced
);
  logic [5:0] stage1;
  logic [5:0] next_stage1;
  logic [5:0] next_synced;

  always_comb
  begin
    next_stage1 = pin_async;
    next_synced = stage1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      stage1     <= 6'h00;
      pin_synced <= 6'h00;
    end
    else
    begin
      stage1     <= next_stage1;
      pin_synced <= next_synced;
    end
  end
endmodule
`default_nettype wire

// >>> six_bit_gpio_port.sv
// Six-pin general-purpose port with direction, options and pin wake logic
`timescale 1ns/1ps
`default_nettype none
module six_bit_gpio_port
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Core side
  input  wire logic [2:0] port_op,
  input  wire logic [2:0] bit_sel,
  input  wire logic [7:0] work_reg,
  input  wire logic       direction_load,
  input  wire logic       options_load,
  input  wire logic       asleep,
  output logic      [7:0] read_data,
  output logic            wake_on_change_flag,
  // Configuration word
  input  wire logic [5:0] alt_function,
  input  wire logic       external_reset_input,
  // Pins
  input  wire logic [5:0] pin_in,
  output logic      [5:0] pin_out,
  output logic      [5:0] pin_oe,
  output logic      [5:0] pull_up_on
);
  // ===================================================
  // State
  logic [5:0] pin_direction;
  logic [7:0] timer_and_pin_options;
  logic [5:0] latch;
  logic [5:0] pins;
  logic [5:0] last_pins;
  logic [5:0] next_direction;
  logic [7:0] next_options;
  logic [5:0] next_latch;
  logic [7:0] next_read_data;
  logic [5:0] next_out;
  logic [5:0] next_oe;
  logic [5:0] next_pull;
  logic       next_wake_flag;
  logic [5:0] visible;
  logic [5:0] drive_ok;
  logic [5:0] weak_ok;
  logic [5:0] wake_ok;
  gpio_port_pkg::port_op_t op;

  assign op = gpio_port_pkg::port_op_t'(port_op);

  pin_sync u_sync
  (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .pin_async  (pin_in),
    .pin_synced (pins)
  );

  // Pin levels as software sees them
  function automatic logic [5:0] port_view(input logic [5:0] lv, input logic [5:0] alt);
    port_view = lv & ~alt;
  endfunction

  // ===================================================
  // Next-state logic
  always_comb
  begin
    next_direction = pin_direction;
    next_options   = timer_and_pin_options;
    next_latch     = latch;
    visible        = port_view(pins, alt_function);
    if (direction_load)
      next_direction = work_reg[5:0];
    if (options_load)
      next_options = work_reg;
    unique case (op)
      gpio_port_pkg::op_write:
        next_latch = work_reg[5:0];
      gpio_port_pkg::op_bit_set:
        next_latch = visible | (6'h01 << bit_sel);
      gpio_port_pkg::op_bit_clear:
        next_latch = visible & ~(6'h01 << bit_sel);
      default:
        next_latch = latch;
    endcase
    // Read sampled from pins synchronised before this cycle began
    next_read_data = (op == gpio_port_pkg::op_read) ? {2'b00, visible} : read_data;

    drive_ok = ~next_direction & ~alt_function;
    drive_ok[gpio_port_pkg::input_only_idx] = 1'b0;
    if (next_options[gpio_port_pkg::opt_timer_src_bit])
      drive_ok[gpio_port_pkg::second_pin_idx] = 1'b0;
    next_out = next_latch;
    next_oe  = drive_ok;

    // Direction zero overrides the option bits
    weak_ok = gpio_port_pkg::weak_pin_mask & next_direction;
    next_pull = next_options[gpio_port_pkg::opt_pull_disable_bit] ? 6'h00 : weak_ok;
    if (external_reset_input)
      next_pull[gpio_port_pkg::input_only_idx] = 1'b1;
    wake_ok = next_options[gpio_port_pkg::opt_wake_disable_bit] ? 6'h00 : weak_ok;
    if (external_reset_input)
      wake_ok[gpio_port_pkg::input_only_idx] = 1'b0;
    // Limitation: a core asleep within three edges of reset would see a false change
    // Flag set on a change while asleep; a read with bit_sel 7 clears it, asleep or awake, set wins
    next_wake_flag = wake_on_change_flag;
    if (op == gpio_port_pkg::op_read && bit_sel == 3'h7)
      next_wake_flag = 1'b0;
    if (asleep && |((pins ^ last_pins) & wake_ok))
      next_wake_flag = 1'b1;
  end

  // ===================================================
  // Registers
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pin_direction         <= gpio_port_pkg::direction_reset;
      timer_and_pin_options <= gpio_port_pkg::options_reset;
      latch                 <= gpio_port_pkg::latch_reset;
      last_pins             <= 6'h00;
      read_data             <= 8'h00;
      pin_out               <= gpio_port_pkg::latch_reset;
      pin_oe                <= 6'h00;
      pull_up_on            <= 6'h00;
      wake_on_change_flag   <= 1'b0;
    end
    else
    begin
      pin_direction         <= next_direction;
      timer_and_pin_options <= next_options;
      latch                 <= next_latch;
      last_pins             <= pins;
      read_data             <= next_read_data;
      pin_out               <= next_out;
      pin_oe                <= next_oe;
      pull_up_on            <= next_pull;
      wake_on_change_flag   <= next_wake_flag;
    end
  end

  // ===================================================
  // Checks
  sequence s_idle_pair;
    op == gpio_port_pkg::op_none ##1 op == gpio_port_pkg::op_none;
  endsequence

  a_reset_inputs: assert property (@(posedge sys_clk) reset |=> pin_oe == 6'h00)
    else $error("pins not tristated after reset");
  a_input_only_quiet: assert property (@(posedge sys_clk) disable iff (reset)
    !pin_oe[3])
    else $error("input-only pin driven");
  a_read_top_zero: assert property (@(posedge sys_clk) disable iff (reset)
    read_data[7:6] == 2'b00)
    else $error("unimplemented bits read nonzero");
  a_read_pins: assert property (@(posedge sys_clk) disable iff (reset)
    op == gpio_port_pkg::op_read |=> read_data[5:0] == ($past(pins) & ~$past(alt_function)))
    else $error("read does not show pins");
  a_dir_load: assert property (@(posedge sys_clk) disable iff (reset)
    direction_load && work_reg[1:0] == 2'b00 && alt_function[1:0] == 2'b00
    |=> pin_oe[1:0] == 2'b11)
    else $error("direction load not applied");
  a_timer_forces: assert property (@(posedge sys_clk) disable iff (reset)
    timer_and_pin_options[5] |-> !pin_oe[2])
    else $error("second pin driven under timer select");
  a_latch_holds: assert property (@(posedge sys_clk) disable iff (reset)
    s_idle_pair |-> $stable(latch))
    else $error("latch changed without write");
  // A direction load in the same cycle may legally turn the pull-up back on
  a_pull_dir_zero: assert property (@(posedge sys_clk) disable iff (reset)
    !direction_load && pin_direction[0] == 1'b0 |=> !pull_up_on[0])
    else $error("pull-up on output pin");
  // Pull outputs leave reset one edge late, so the edge after release is exempt
  a_external_reset_input_pull: assert property (@(posedge sys_clk) disable iff (reset)
    !$past(reset) && $past(external_reset_input) |-> pull_up_on[3])
    else $error("reset pin pull-up off");
  a_bit_set: assert property (@(posedge sys_clk) disable iff (reset)
    op == gpio_port_pkg::op_bit_set && bit_sel == 3'h0 |=> latch[0])
    else $error("bit set lost");
endmodule
`default_nettype wire

// >>> six_bit_gpio_port_test.sv
// Self-checking bench for the six-pin port
`timescale 1ns/1ps
`default_nettype none
module six_bit_gpio_port_test;
  logic       sys_clk = 1'b0;
  logic       reset = 1'b1;
  logic [2:0] port_op = 3'h0;
  logic [2:0] bit_sel = 3'h0;
  logic [7:0] work_reg = 8'h00;
  logic       direction_load = 1'b0;
  logic       options_load = 1'b0;
  logic       asleep = 1'b0;
  logic [5:0] alt_function = 6'h00;
  logic       external_reset_input = 1'b0;
  logic [5:0] ext_level = 6'h2d;
  logic [5:0] ext_drive = 6'h3f;
  logic [5:0] pin_in, pin_out, pin_oe, pull_up_on;
  logic [7:0] read_data;
  logic       wake_on_change_flag;
  int         n_errors = 0;
  int         total_checks = 0;
  int         i;
  // ==========================================
  // Clock, design and pin load
  initial forever #25 sys_clk = ~sys_clk;
  six_bit_gpio_port u_dut (.sys_clk(sys_clk), .reset(reset), .port_op(port_op),
    .bit_sel(bit_sel), .work_reg(work_reg), .direction_load(direction_load),
    .options_load(options_load), .asleep(asleep), .read_data(read_data),
    .wake_on_change_flag(wake_on_change_flag), .alt_function(alt_function),
    .external_reset_input(external_reset_input), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pull_up_on(pull_up_on));
  pin_load_model u_load (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_on(pull_up_on), .ext_level(ext_level), .ext_drive(ext_drive), .pin_in(pin_in));
  // ==========================================
  // Access tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One core request, then enough edges for pins to settle through the synchroniser
  task automatic issue(input logic [2:0] op, input logic [2:0] sel, input logic [7:0] w,
                       input logic dl, input logic ol);
    @(posedge sys_clk);
    port_op <= op;
    bit_sel <= sel;
    work_reg <= w;
    direction_load <= dl;
    options_load <= ol;
    @(posedge sys_clk);
    port_op <= 3'h0;
    direction_load <= 1'b0;
    options_load <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic rd(input string what, input logic [7:0] exp);
    issue(gpio_port_pkg::op_read, 3'h0, 8'h00, 1'b0, 1'b0);
    chk(what, exp, read_data);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================
  // Tests
  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk("oe after reset", 8'h00, {2'b00, pin_oe});
    rd("pins as inputs", 8'h2d);
    $display("test reset done");
    issue(gpio_port_pkg::op_write, 3'h0, 8'hd5, 1'b0, 1'b0);
    issue(gpio_port_pkg::op_none, 3'h0, 8'h00, 1'b1, 1'b0);
    chk("oe timer src", 8'h33, {2'b00, pin_oe});
    chk("out latch", 8'h15, {2'b00, pin_out});
    rd("mixed pins", 8'h1d);
    alt_function <= 6'h01;
    issue(gpio_port_pkg::op_none, 3'h0, 8'h00, 1'b0, 1'b1);
    chk("oe alt", 8'h36, {2'b00, pin_oe});
    chk("pull when out", 8'h00, {6'h00, pull_up_on[1:0]});
    rd("alt reads zero", 8'h1c);
    $display("test direction done");
    alt_function <= 6'h00;
    ext_level <= 6'h2a;
    issue(gpio_port_pkg::op_none, 3'h0, 8'h3f, 1'b1, 1'b0);
    chk("shared pulls", 8'h0b, {2'b00, pull_up_on});
    issue(gpio_port_pkg::op_bit_clear, 3'h5, 8'h00, 1'b0, 1'b0);
    issue(gpio_port_pkg::op_bit_set, 3'h0, 8'h00, 1'b0, 1'b0);
    issue(gpio_port_pkg::op_none, 3'h0, 8'h00, 1'b1, 1'b0);
    chk("rmw latch", 8'h2b, {2'b00, pin_out});
    $display("test bit ops done");
    issue(gpio_port_pkg::op_none, 3'h0, 8'h3f, 1'b1, 1'b0);
    external_reset_input <= 1'b1;
    asleep <= 1'b1;
    issue(gpio_port_pkg::op_none, 3'h0, 8'h40, 1'b0, 1'b1);
    chk("reset pin pull", 8'h08, {2'b00, pull_up_on});
    ext_level <= 6'h22;
    repeat (8) @(posedge sys_clk);
    chk("no wake on reset pin", 8'h00, {7'h00, wake_on_change_flag});
    ext_level <= 6'h23;
    for (i = 0; i < 20 && wake_on_change_flag !== 1'b1; i++)
      @(posedge sys_clk);
    chk("wake on pin zero", 8'h01, {7'h00, wake_on_change_flag});
    asleep <= 1'b0;
    issue(gpio_port_pkg::op_read, 3'h7, 8'h00, 1'b0, 1'b0);
    chk("flag cleared", 8'h00, {7'h00, wake_on_change_flag});
    // Let the input-only pin float so only its forced pull-up sets the level
    ext_drive <= 6'h37;
    repeat (2) @(posedge sys_clk);
    rd("pulled reset pin", 8'h2b);
    $display("test wake done");
    issue(gpio_port_pkg::op_none, 3'h0, 8'h00, 1'b1, 1'b0);
    chk("oe before reset", 8'h37, {2'b00, pin_oe});
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk("oe after mid reset", 8'h00, {2'b00, pin_oe});
    @(posedge sys_clk);
    chk("reset pin pull kept", 8'h08, {2'b00, pull_up_on});
    rd("pins after mid reset", 8'h2b);
    issue(gpio_port_pkg::op_none, 3'h0, 8'h00, 1'b1, 1'b0);
    chk("options after reset", 8'h33, {2'b00, pin_oe});
    $display("test mid reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
